// file: design/keypad_wake_unit.sv
// Top of the keypad wake unit: registers, event flag and wake requests.
`default_nettype none

module keypad_wake_unit
  import keypad_wake_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  first_gpio_port,
  input  wire logic [1:0]  display_seg_active,
  input  wire logic        shallow_stop_mode,
  input  wire logic        deep_stop_mode,
  output logic             irq_req,
  output logic             wake_req,
  output logic      [7:0]  pull_down_sel
);

  typedef struct packed {
    logic       detect_mode;
    logic       irq_enable;
    logic       event_flag;
    logic [7:0] enable_mask;
    logic [7:0] polarity;
    logic       clock_gate;
  } unit_state_s;

  localparam unit_state_s UNIT_RST = '{
    detect_mode: DETECT_MODE_RST,
    irq_enable:  IRQ_ENABLE_RST,
    event_flag:  EVENT_FLAG_RST,
    enable_mask: ENABLE_MASK_RST,
    polarity:    POLARITY_RST,
    clock_gate:  CLOCK_GATE_RST
  };

  unit_state_s state_ff;
  unit_state_s nxt_state;
  logic [7:0]  display_block;
  logic [7:0]  live_enable;
  logic        status_write;
  logic        ack_write;
  logic        any_edge;
  logic        any_level;
  logic        set_flag;
  logic        clear_flag;

  detect_if det ();
  reg_if    rg ();

  apb_access u_apb_access (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rg      (rg.port)
  );

  detect_bank u_detect_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .det     (det.bank)
  );

  // The shared inputs would see segment drive as keypresses, so they are
  // masked for as long as the display owns them.
  always_comb
  begin
    display_block                = 8'h00;
    display_block[SHARED_PIN_LO] = display_seg_active[0];
    display_block[SHARED_PIN_HI] = display_seg_active[1];
  end

  assign live_enable   = state_ff.enable_mask & ~display_block;
  assign det.pin_level = first_gpio_port;
  assign det.enable    = live_enable;
  assign det.polarity  = state_ff.polarity;
  assign det.step      = state_ff.clock_gate;
  assign det.flush     = deep_stop_mode;

  assign any_edge     = |det.edge_seen;
  assign any_level    = |det.asserted;
  assign status_write = rg.wr_en && rg.addr == STATUS_CONTROL_OFFS &&
                        state_ff.clock_gate;
  assign ack_write    = status_write && rg.wdata[EVENT_ACK_BIT];

  // Level mode also raises the flag from any held asserted input.
  assign set_flag   = state_ff.clock_gate &&
                      (any_edge ||
                       (state_ff.detect_mode && any_level));
  // In level mode the acknowledge only clears once all inputs are released.
  assign clear_flag = ack_write &&
                      (!state_ff.detect_mode || !any_level);

  always_comb
  begin
    nxt_state = state_ff;
    if (deep_stop_mode)
    begin
      nxt_state = UNIT_RST;
    end
    else
    begin
      if (rg.wr_en && rg.addr == CLOCK_GATE_OFFS)
      begin
        nxt_state.clock_gate = rg.wdata[CLOCK_GATE_BIT];
      end
      if (status_write)
      begin
        nxt_state.detect_mode = rg.wdata[DETECT_MODE_BIT];
        nxt_state.irq_enable  = rg.wdata[IRQ_ENABLE_BIT];
      end
      if (rg.wr_en && rg.addr == ENABLE_MASK_OFFS && state_ff.clock_gate)
      begin
        nxt_state.enable_mask = rg.wdata;
      end
      if (rg.wr_en && rg.addr == POLARITY_SEL_OFFS && state_ff.clock_gate)
      begin
        nxt_state.polarity = rg.wdata;
      end
      // A new event in the acknowledge cycle is kept: set beats clear.
      if (set_flag)
      begin
        nxt_state.event_flag = 1'b1;
      end
      else if (clear_flag)
      begin
        nxt_state.event_flag = 1'b0;
      end
    end
  end

  // The flag bit is never taken from write data, and the acknowledge bit always reads as zero.
  always_comb
  begin
    rg.rd_data = READ_ZERO;
    unique case (rg.addr)
      STATUS_CONTROL_OFFS:
      begin
        rg.rd_data[EVENT_FLAG_BIT]  = state_ff.event_flag;
        rg.rd_data[EVENT_ACK_BIT]   = 1'b0;
        rg.rd_data[IRQ_ENABLE_BIT]  = state_ff.irq_enable;
        rg.rd_data[DETECT_MODE_BIT] = state_ff.detect_mode;
      end
      ENABLE_MASK_OFFS:
      begin
        rg.rd_data = state_ff.enable_mask;
      end
      POLARITY_SEL_OFFS:
      begin
        rg.rd_data = state_ff.polarity;
      end
      CLOCK_GATE_OFFS:
      begin
        rg.rd_data[CLOCK_GATE_BIT] = state_ff.clock_gate;
      end
      default:
      begin
        rg.rd_data = READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= UNIT_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // There is no debug-halt input: halting the core leaves this unit
  // running exactly as in run mode.
  assign irq_req = state_ff.irq_enable & state_ff.event_flag;

  // In shallow stop the clock is gone, so an asserted enabled level is
  // passed on without a flip-flop; the flag catches up once it returns.
  assign wake_req = state_ff.irq_enable &
                    (state_ff.event_flag |
                     (shallow_stop_mode & any_level));

  // Pull-down when polarity is high, pull-up otherwise.
  assign pull_down_sel = state_ff.polarity;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  edge_sets_flag_a: assert property (
    state_ff.clock_gate && any_edge && !deep_stop_mode
    |=> state_ff.event_flag ##0 irq_req == state_ff.irq_enable)
    else $error("Enabled edge did not set the event flag.");

  ack_clears_edge_a: assert property (
    ack_write && !state_ff.detect_mode && !any_edge && !deep_stop_mode
    |=> !state_ff.event_flag)
    else $error("Acknowledge in edge mode left the flag set.");

  level_holds_flag_a: assert property (
    state_ff.clock_gate && state_ff.detect_mode && any_level &&
    !deep_stop_mode ##0 ack_write
    |=> state_ff.event_flag [*1])
    else $error("Acknowledge cleared the flag with a level asserted.");

  flag_write_ignored_a: assert property (
    status_write && rg.wdata[EVENT_FLAG_BIT] && !state_ff.event_flag &&
    !set_flag && !deep_stop_mode
    |=> !state_ff.event_flag)
    else $error("Writing the flag bit set the flag.");

  deep_stop_reset_a: assert property (
    deep_stop_mode |=> state_ff.enable_mask == ENABLE_MASK_RST &&
    !state_ff.event_flag && !irq_req && state_ff.clock_gate)
    else $error("Deep stop did not return the unit to reset.");

  gate_freeze_a: assert property (
    !state_ff.clock_gate && !deep_stop_mode
    |=> $stable(state_ff.event_flag) && $stable(state_ff.polarity))
    else $error("Unit changed state while its clock was gated.");

  shallow_wake_a: assert property (
    shallow_stop_mode && state_ff.irq_enable && any_level |-> wake_req)
    else $error("Asserted input did not wake from shallow stop.");

  masked_irq_a: assert property (
    $fell(state_ff.irq_enable)
    |-> !irq_req ##1 (!irq_req || state_ff.irq_enable))
    else $error("Interrupt request with interrupts disabled.");

  display_pin_a: assert property (
    display_seg_active[0] |-> !det.edge_seen[SHARED_PIN_LO] &&
    !det.asserted[SHARED_PIN_LO])
    else $error("Display-owned input took part in detection.");

  display_pin_hi_a: assert property (
    display_seg_active[1] |-> !det.edge_seen[SHARED_PIN_HI] &&
    !det.asserted[SHARED_PIN_HI])
    else $error("Second display-owned input took part in detection.");

  masked_pin_a: assert property (
    !state_ff.enable_mask[0] |-> !det.asserted[0] && !det.edge_seen[0])
    else $error("Disabled input took part in detection.");

  irq_off_a: assert property (
    !state_ff.irq_enable |-> !irq_req && !wake_req)
    else $error("Request raised with interrupts disabled.");

  wait_wake_a: assert property (
    state_ff.irq_enable && state_ff.event_flag |-> wake_req)
    else $error("Pending event did not raise a wake request.");

  level_sets_flag_a: assert property (
    state_ff.clock_gate && state_ff.detect_mode && any_level &&
    !deep_stop_mode |=> state_ff.event_flag)
    else $error("Asserted level in level mode left the flag clear.");

  edge_only_a: assert property (
    !state_ff.detect_mode && !any_edge && !state_ff.event_flag &&
    !deep_stop_mode |=> !state_ff.event_flag)
    else $error("Flag set in edge mode without an edge.");

  enable_write_a: assert property (
    rg.wr_en && rg.addr == ENABLE_MASK_OFFS && state_ff.clock_gate &&
    !deep_stop_mode |=> state_ff.enable_mask == $past(rg.wdata))
    else $error("Enable mask write did not land.");

  polarity_write_a: assert property (
    rg.wr_en && rg.addr == POLARITY_SEL_OFFS && state_ff.clock_gate &&
    !deep_stop_mode |=> pull_down_sel == $past(rg.wdata))
    else $error("Polarity write did not reach the pull selects.");

  gated_write_a: assert property (
    !state_ff.clock_gate && rg.wr_en && rg.addr == ENABLE_MASK_OFFS &&
    !deep_stop_mode |=> $stable(state_ff.enable_mask))
    else $error("Register changed by a write while the clock was gated.");

endmodule

`default_nettype wire

// file: design/keypad_wake_pkg.sv
// Constants, register map and field layout of the keypad wake unit.
`default_nettype none

package keypad_wake_pkg;

  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned REG_W     = 8;

  // Byte addresses of the registers on the APB bus.
  localparam logic [11:0] STATUS_CONTROL_OFFS = 12'h000;
  localparam logic [11:0] ENABLE_MASK_OFFS    = 12'h004;
  localparam logic [11:0] POLARITY_SEL_OFFS   = 12'h008;
  localparam logic [11:0] CLOCK_GATE_OFFS     = 12'h00C;

  // Field positions inside event_status_control.
  localparam int unsigned EVENT_FLAG_BIT  = 3;
  localparam int unsigned EVENT_ACK_BIT   = 2;
  localparam int unsigned IRQ_ENABLE_BIT  = 1;
  localparam int unsigned DETECT_MODE_BIT = 0;

  // Field position inside the clock gate register.
  localparam int unsigned CLOCK_GATE_BIT = 0;

  // Reset values.
  localparam logic       DETECT_MODE_RST  = 1'b0;
  localparam logic       IRQ_ENABLE_RST   = 1'b0;
  localparam logic       EVENT_FLAG_RST   = 1'b0;
  localparam logic [7:0] ENABLE_MASK_RST  = 8'h00;
  localparam logic [7:0] POLARITY_RST     = 8'h00;
  localparam logic       CLOCK_GATE_RST   = 1'b1;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // Input pins shared with display segments.
  localparam int unsigned SHARED_PIN_LO = 4;
  localparam int unsigned SHARED_PIN_HI = 5;

endpackage

`default_nettype wire

// file: design/keypad_links_if.sv
// Interfaces that join the keypad wake unit to its detector and bus port.
`default_nettype none

interface detect_if;
  logic [7:0] pin_level;
  logic [7:0] enable;
  logic [7:0] polarity;
  logic       step;
  logic       flush;
  logic [7:0] asserted;
  logic [7:0] edge_seen;

  modport ctrl (
    output pin_level,
    output enable,
    output polarity,
    output step,
    output flush,
    input  asserted,
    input  edge_seen
  );

  modport bank (
    input  pin_level,
    input  enable,
    input  polarity,
    input  step,
    input  flush,
    output asserted,
    output edge_seen
  );
endinterface

interface reg_if;
  logic        wr_en;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rd_data;

  modport port (
    output wr_en,
    output addr,
    output wdata,
    input  rd_data
  );

  modport regs (
    input  wr_en,
    input  addr,
    input  wdata,
    output rd_data
  );
endinterface

`default_nettype wire

// file: design/detect_bank.sv
// Per-pin polarity, arming and edge detection for the eight wake inputs.
`default_nettype none

module detect_bank
  import keypad_wake_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  detect_if.bank    det
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] armed;
  } bank_state_s;

  bank_state_s          state_ff;
  bank_state_s          nxt_state;
  logic [PIN_COUNT-1:0] active_level;

  // Polarity 1 takes a high level as asserted, polarity 0 a low level.
  assign active_level  = ~(det.pin_level ^ det.polarity);
  assign det.asserted  = active_level & det.enable;
  // A pin is armed only after a deasserted sample while enabled.
  assign det.edge_seen = det.enable & state_ff.armed & active_level;

  always_comb
  begin
    nxt_state = state_ff;
    if (det.flush)
    begin
      nxt_state.armed = '0;
    end
    else if (det.step)
    begin
      nxt_state.armed = det.enable & ~active_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  asserted_on_enable_a: assert property (
    $rose(det.enable[1]) && active_level[1] |-> !det.edge_seen[1])
    else $error("Edge reported for a pin already asserted when enabled.");

  fall_then_rise_a: assert property (
    det.step && !det.flush && det.enable[1] && !active_level[1]
    ##1 det.enable[1] && active_level[1] |-> det.edge_seen[1])
    else $error("Deasserted then asserted sample gave no edge.");

endmodule

`default_nettype wire

// file: design/apb_access.sv
// APB slave port of the keypad wake unit with registered read data.
`default_nettype none

module apb_access
  import keypad_wake_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  reg_if.port              rg
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } port_state_s;

  port_state_s state_ff;
  port_state_s nxt_state;
  logic        mapped;

  assign mapped = (paddr == STATUS_CONTROL_OFFS) ||
                  (paddr == ENABLE_MASK_OFFS) ||
                  (paddr == POLARITY_SEL_OFFS) ||
                  (paddr == CLOCK_GATE_OFFS);

  // Every access completes in its first access cycle.
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign rg.wr_en = psel & penable & pwrite & mapped;
  assign rg.addr  = paddr;
  assign rg.wdata = pwdata[REG_W-1:0];
  assign prdata   = state_ff.rdata;

  // Read data is caught in the setup cycle so that it leaves a flip-flop.
  always_comb
  begin
    nxt_state = state_ff;
    if (psel && !penable && !pwrite)
    begin
      nxt_state.rdata = mapped ? {24'h00_0000, rg.rd_data} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ack_reads_zero_a: assert property (
    psel && penable && !pwrite && paddr == STATUS_CONTROL_OFFS
    |-> prdata[EVENT_ACK_BIT] == 1'b0)
    else $error("Acknowledge bit read back as one.");

endmodule

`default_nettype wire

// file: test/key_switch_bank.sv
// Key switch model that drives the wake input pins against their pulls.
`default_nettype none

module key_switch_bank (
  input  wire logic [7:0] pull_down_sel,
  input  wire logic [7:0] key_down,
  output logic      [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // An open key leaves its pin at the selected pull level, and a closed
  // key pulls it to the far rail, so the pin never floats to an unknown.
  assign pin_level = ~(pull_down_sel ^ key_down);
endmodule

`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the keypad wake unit over APB.
`default_nettype none

module tb_top
  import keypad_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  keys;
  logic [7:0]  pins;
  logic [1:0]  disp;
  logic        sstop;
  logic        dstop;
  logic        irq_req;
  logic        wake_req;
  logic [7:0]  pull_down_sel;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          n_tests;

  keypad_wake_unit dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .first_gpio_port    (pins),
    .display_seg_active (disp),
    .shallow_stop_mode  (sstop),
    .deep_stop_mode     (dstop),
    .irq_req            (irq_req),
    .wake_req           (wake_req),
    .pull_down_sel      (pull_down_sel)
  );

  key_switch_bank keys_model (
    .pull_down_sel (pull_down_sel),
    .key_down      (keys),
    .pin_level     (pins)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The master waits for pready and checks that the slave adds no wait state.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    check("pready", n, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string name, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask

  function automatic logic [31:0] sv(input int f, input int ie,
                                     input int m);
    return {28'h000_0000, f[0], 1'b0, ie[0], m[0]};
  endfunction

  task automatic wait3();
    repeat (3) @(posedge pclk);
  endtask

  task automatic arm(input logic [7:0] pol, input logic [7:0] en,
                     input logic m);
    wr(STATUS_CONTROL_OFFS, sv(0, 0, int'(m)));
    wr(ENABLE_MASK_OFFS, 32'h0000_0000);
    wr(POLARITY_SEL_OFFS, {24'h00_0000, pol});
    wr(ENABLE_MASK_OFFS, {24'h00_0000, en});
    wr(STATUS_CONTROL_OFFS, {28'h000_0000, 2'b01, 1'b0, m});
    wr(STATUS_CONTROL_OFFS, sv(0, 1, int'(m)));
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    keys = 8'h00;
    disp = 2'b00;
    sstop = 1'b0;
    dstop = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status", STATUS_CONTROL_OFFS, 32'h0000_0000);
    rchk("enable", ENABLE_MASK_OFFS, 32'h0000_0000);
    rchk("polarity", POLARITY_SEL_OFFS, 32'h0000_0000);
    rchk("gate", CLOCK_GATE_OFFS, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped error", {31'h0, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    wr(12'h010, 32'h0000_00ff);
    check("unmapped write", {31'h0, err}, 32'h0000_0001);
    $display("test reset done");

    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
      begin
        arm(p[0] ? 8'hff : 8'h00, 8'(1 << i), 1'b0);
        check("pull", {24'h0, pull_down_sel}, {24'h0, {8{p[0]}}});
        keys <= 8'(1 << ((i + 1) % 8));
        wait3();
        rchk("other pin", STATUS_CONTROL_OFFS, sv(0, 1, 0));
        keys <= 8'(1 << i);
        wait3();
        rchk("pin event", STATUS_CONTROL_OFFS, sv(1, 1, 0));
        @(negedge pclk);
        check("irq", {31'h0, irq_req}, 32'h0000_0001);
        wr(STATUS_CONTROL_OFFS, 32'h0000_0006);
        rchk("ack", STATUS_CONTROL_OFFS, sv(0, 1, 0));
        keys <= 8'h00;
      end
    $display("test pins done");

    arm(8'h00, 8'h02, 1'b0);
    wr(STATUS_CONTROL_OFFS, 32'h0000_0008);
    rchk("flag write", STATUS_CONTROL_OFFS, sv(0, 0, 0));
    keys <= 8'h02;
    wait3();
    @(negedge pclk);
    check("masked irq", {31'h0, irq_req}, 32'h0000_0000);
    rchk("masked flag", STATUS_CONTROL_OFFS, sv(1, 0, 0));
    arm(8'h00, 8'h02, 1'b0);
    wait3();
    rchk("held pin", STATUS_CONTROL_OFFS, sv(0, 1, 0));
    keys <= 8'h00;
    wait3();
    keys <= 8'h02;
    wait3();
    rchk("rearmed", STATUS_CONTROL_OFFS, sv(1, 1, 0));
    $display("test arming done");

    keys <= 8'h00;
    arm(8'h00, 8'h01, 1'b1);
    keys <= 8'h01;
    wait3();
    wr(STATUS_CONTROL_OFFS, 32'h0000_0007);
    rchk("level hold", STATUS_CONTROL_OFFS, sv(1, 1, 1));
    keys <= 8'h00;
    wait3();
    wr(STATUS_CONTROL_OFFS, 32'h0000_0007);
    rchk("level clear", STATUS_CONTROL_OFFS, sv(0, 1, 1));
    $display("test level done");

    for (int k = 0; k < 2; k++)
    begin
      arm(8'h00, 8'(8'h10 << k), 1'b0);
      disp <= 2'(1 << k);
      keys <= 8'(8'h10 << k);
      wait3();
      rchk("display pin", STATUS_CONTROL_OFFS, sv(0, 1, 0));
      keys <= 8'h00;
      disp <= 2'b00;
      wait3();
      keys <= 8'(8'h10 << k);
      wait3();
      rchk("freed pin", STATUS_CONTROL_OFFS, sv(1, 1, 0));
      keys <= 8'h00;
    end
    $display("test display done");

    arm(8'h00, 8'h01, 1'b0);
    wr(CLOCK_GATE_OFFS, 32'h0000_0000);
    wr(ENABLE_MASK_OFFS, 32'h0000_00ff);
    rchk("gated write", ENABLE_MASK_OFFS, 32'h0000_0001);
    sstop <= 1'b1;
    keys <= 8'h01;
    @(negedge pclk);
    check("stop wake", {31'h0, wake_req}, 32'h0000_0001);
    check("gated irq", {31'h0, irq_req}, 32'h0000_0000);
    @(posedge pclk);
    keys <= 8'h00;
    sstop <= 1'b0;
    wr(CLOCK_GATE_OFFS, 32'h0000_0001);
    $display("test stop done");

    arm(8'hff, 8'hff, 1'b1);
    @(posedge pclk);
    dstop <= 1'b1;
    @(posedge pclk);
    dstop <= 1'b0;
    rchk("deep status", STATUS_CONTROL_OFFS, 32'h0000_0000);
    rchk("deep enable", ENABLE_MASK_OFFS, 32'h0000_0000);
    rchk("deep polarity", POLARITY_SEL_OFFS, 32'h0000_0000);
    rchk("deep gate", CLOCK_GATE_OFFS, 32'h0000_0001);
    $display("test deep stop done");
    print_verdict();
  end
endmodule

`default_nettype wire
